/* File: rtl/rcfd_pkg.sv */
// Purpose: constants for the reference clock fractional divider
// Assumes: 16-bit register data, register index addressing
// Notes: offsets are register indices on the plain register port
package rcfd_pkg;

	// register port shape
	localparam int ADDR_W = 2;
	localparam int DATA_W = 16;

	// register indices
	localparam logic [1:0] OFS_CTRL = 2'h0;
	localparam logic [1:0] OFS_DIVISOR_HIGH = 2'h1;
	localparam logic [1:0] OFS_FRACTION_TRIM = 2'h2;

	// control / status register fields
	localparam int CTRL_SWITCH_BIT = 0;
	localparam int CTRL_BYPASS_BIT = 1;
	localparam int CTRL_LEVEL_BIT = 2;

	// divisor register field
	localparam int DIV_W = 15;
	localparam int DIV_LSB = 0;
	localparam int DIV_MSB = 14;

	// trim register field
	localparam int FRAC_W = 9;
	localparam int FRAC_LSB = 7;
	localparam int FRAC_MSB = 15;

	// half period count width: divisor plus one carry cycle
	localparam int CNT_W = 16;

	// reset values
	localparam logic [DIV_W-1:0] DIV_RESET = 15'h0000;
	localparam logic [FRAC_W-1:0] FRAC_RESET = 9'h000;
	localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
	localparam logic [DATA_W-1:0] RDATA_RESET = 16'h0000;

	// divider modes
	typedef enum logic [0:0]
	{
		RCFD_BYPASS = 1'b0,
		RCFD_DIVIDE = 1'b1
	} rcfd_mode_e;

endpackage

/* File: rtl/rcfd_frac_acc.sv */
// Purpose: fraction accumulator for the half period trim
// Assumes: step pulses once per finished half period
// Notes: carry out lengthens the running half period by one cycle
`timescale 1ns/100ps

module rcfd_frac_acc
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// control
	input wire logic clear,
	input wire logic step,
	input wire logic [rcfd_pkg::FRAC_W-1:0] fraction,
	// result
	output logic extend
);

	logic [rcfd_pkg::FRAC_W-1:0] acc_q;
	logic [rcfd_pkg::FRAC_W-1:0] acc_d;
	logic [rcfd_pkg::FRAC_W:0] sum;

	// modulo 512 sum, carry is the extra cycle
	assign sum = {1'b0, acc_q} + {1'b0, fraction};
	assign extend = sum[rcfd_pkg::FRAC_W];
	assign acc_d = clear ? rcfd_pkg::FRAC_RESET : (step ? sum[rcfd_pkg::FRAC_W-1:0] : acc_q);

	always_ff @(posedge clk)
	begin
		if (rst)
			acc_q <= rcfd_pkg::FRAC_RESET;
		else
			acc_q <= acc_d;
	end

endmodule

/* File: rtl/rcfd_divider.sv */
// Purpose: reference clock output divider with fractional half period
// Assumes: clk is the selected base clock; register port is synchronous
// Notes: divisor zero passes clk through combinationally
// Function
// - 15-bit integer divisor held in bits 14..0 of divisor register
// - nonzero divisor N divides base clock by 2N, up to 65,534
// - divisor one divides by 2, divisor two divides by 4
// - divisor zero passes base clock through, trim ignored
// - 9-bit trim held in bits 15..7 of trim register, 1/512 units
// - trim k adds k/512 base cycle to each half period
// - unimplemented register bits read back as zero
// - software waits idle, writes values, sets request; hardware clears when applied
// - with nonzero divisor, output period is twice the sum of divisor and trim, in base cycles
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps

module rcfd_divider
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// register port
	input wire logic [rcfd_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [rcfd_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [rcfd_pkg::DATA_W-1:0] reg_rdata,
	// clock output and switch request status
	output logic divided_clock_output,
	output logic divider_switch_request
);

	// software copies
	logic [rcfd_pkg::DIV_W-1:0] half_period_divisor_q;
	logic [rcfd_pkg::DIV_W-1:0] half_period_divisor_d;
	logic [rcfd_pkg::FRAC_W-1:0] half_period_fraction_q;
	logic [rcfd_pkg::FRAC_W-1:0] half_period_fraction_d;
	logic switch_q;
	logic switch_d;

	// running copies
	logic [rcfd_pkg::DIV_W-1:0] run_div_q;
	logic [rcfd_pkg::DIV_W-1:0] run_div_d;
	logic [rcfd_pkg::FRAC_W-1:0] run_frac_q;
	logic [rcfd_pkg::FRAC_W-1:0] run_frac_d;
	rcfd_pkg::rcfd_mode_e mode_q;
	rcfd_pkg::rcfd_mode_e mode_d;

	// half period counter and output level
	logic [rcfd_pkg::CNT_W-1:0] cnt_q;
	logic [rcfd_pkg::CNT_W-1:0] cnt_d;
	logic level_q;
	logic level_d;

	// read data
	logic [rcfd_pkg::DATA_W-1:0] rdata_q;
	logic [rcfd_pkg::DATA_W-1:0] rdata_d;

	// decode
	logic wr_ctrl;
	logic wr_div;
	logic wr_frac;
	logic extend;
	logic [rcfd_pkg::CNT_W-1:0] half_len;
	logic half_end;
	logic apply;
	logic bypass;
	logic [rcfd_pkg::DATA_W-1:0] rd_ctrl;
	logic [rcfd_pkg::DATA_W-1:0] rd_div;
	logic [rcfd_pkg::DATA_W-1:0] rd_frac;
	logic [rcfd_pkg::DATA_W-1:0] rd_sel;

	// decoded names of the next values
	logic rd_is_ctrl;
	logic rd_is_div;
	logic rd_is_frac;
	logic wr_switch;
	logic restart;
	logic div_is_zero;
	rcfd_pkg::rcfd_mode_e next_mode;
	logic [rcfd_pkg::CNT_W-1:0] base_len;
	logic [rcfd_pkg::CNT_W-1:0] carry_len;
	logic [rcfd_pkg::CNT_W-1:0] half_last;
	logic [rcfd_pkg::CNT_W-1:0] cnt_next;
	logic level_flip;

	// strobe aimed at one register index
	function automatic logic hit
	(
		input logic strobe,
		input logic [rcfd_pkg::ADDR_W-1:0] a,
		input logic [rcfd_pkg::ADDR_W-1:0] ofs
	);
	begin
		hit = strobe && (a == ofs);
	end
	endfunction

	// write decode
	assign wr_ctrl = hit(reg_wr, reg_addr, rcfd_pkg::OFS_CTRL);
	assign wr_div = hit(reg_wr, reg_addr, rcfd_pkg::OFS_DIVISOR_HIGH);
	assign wr_frac = hit(reg_wr, reg_addr, rcfd_pkg::OFS_FRACTION_TRIM);

	// software copies take the write, no effect on running output yet
	assign half_period_divisor_d = wr_div ? reg_wdata[rcfd_pkg::DIV_MSB:rcfd_pkg::DIV_LSB]
		: half_period_divisor_q;
	assign half_period_fraction_d = wr_frac ? reg_wdata[rcfd_pkg::FRAC_MSB:rcfd_pkg::FRAC_LSB]
		: half_period_fraction_q;

	// fraction accumulator, cleared whenever new values take over
	rcfd_frac_acc u_frac_acc
	(
		.clk(clk),
		.rst(rst),
		.clear(apply),
		.step(half_end),
		.fraction(run_frac_q),
		.extend(extend)
	);

	// half period: divisor cycles plus carried cycle
	assign bypass = (mode_q == rcfd_pkg::RCFD_BYPASS);
	assign base_len = {1'b0, run_div_q};
	assign carry_len = {{(rcfd_pkg::CNT_W-1){1'b0}}, extend};
	assign half_len = base_len + carry_len;
	assign half_last = half_len - 16'h0001;
	assign half_end = !bypass && (cnt_q == half_last);

	// new values taken at a half period boundary, or at once in pass-through
	assign restart = bypass || half_end;
	assign apply = switch_q && restart;
	assign wr_switch = wr_ctrl && reg_wdata[rcfd_pkg::CTRL_SWITCH_BIT];
	assign switch_d = wr_switch || (switch_q && !apply);

	// staged values move to the running copies on apply
	assign run_div_d = apply ? half_period_divisor_q : run_div_q;
	assign run_frac_d = apply ? half_period_fraction_q : run_frac_q;

	// mode follows the staged divisor, zero means pass-through
	assign div_is_zero = (half_period_divisor_q == rcfd_pkg::DIV_RESET);
	assign next_mode = div_is_zero ? rcfd_pkg::RCFD_BYPASS : rcfd_pkg::RCFD_DIVIDE;
	assign mode_d = apply ? next_mode : mode_q;

	// counter restarts each half period, level toggles at each end
	assign cnt_next = cnt_q + 16'h0001;
	assign cnt_d = restart ? rcfd_pkg::CNT_RESET : cnt_next;
	assign level_flip = half_end ? !level_q : level_q;
	assign level_d = bypass ? 1'b0 : level_flip;

	// pass-through of base clock when divisor is zero, trim unused
	assign divided_clock_output = bypass ? clk : level_q;
	assign divider_switch_request = switch_q;

	// read mux, unimplemented bits forced to zero
	assign rd_ctrl = {{(rcfd_pkg::DATA_W-3){1'b0}}, level_q, bypass, switch_q};
	assign rd_div = {1'b0, half_period_divisor_q};
	assign rd_frac = {half_period_fraction_q, 7'h00};
	assign rd_is_ctrl = hit(reg_rd, reg_addr, rcfd_pkg::OFS_CTRL);
	assign rd_is_div = hit(reg_rd, reg_addr, rcfd_pkg::OFS_DIVISOR_HIGH);
	assign rd_is_frac = hit(reg_rd, reg_addr, rcfd_pkg::OFS_FRACTION_TRIM);
	assign rd_sel = rd_is_ctrl ? rd_ctrl
		: rd_is_div ? rd_div
		: rd_is_frac ? rd_frac
		: rcfd_pkg::RDATA_RESET;
	assign rdata_d = rd_sel;
	assign reg_rdata = rdata_q;

	// staged divisor
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			half_period_divisor_q <= rcfd_pkg::DIV_RESET;
		end
		else
		begin
			half_period_divisor_q <= half_period_divisor_d;
		end
	end

	// staged trim
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			half_period_fraction_q <= rcfd_pkg::FRAC_RESET;
		end
		else
		begin
			half_period_fraction_q <= half_period_fraction_d;
		end
	end

	// switch request, set by software, cleared on apply
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			switch_q <= 1'b0;
		end
		else
		begin
			switch_q <= switch_d;
		end
	end

	// read data, one cycle after the strobe
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rdata_q <= rcfd_pkg::RDATA_RESET;
		end
		else
		begin
			rdata_q <= rdata_d;
		end
	end

	// running divisor
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			run_div_q <= rcfd_pkg::DIV_RESET;
		end
		else
		begin
			run_div_q <= run_div_d;
		end
	end

	// running trim
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			run_frac_q <= rcfd_pkg::FRAC_RESET;
		end
		else
		begin
			run_frac_q <= run_frac_d;
		end
	end

	// pass-through or divide
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			mode_q <= rcfd_pkg::RCFD_BYPASS;
		end
		else
		begin
			mode_q <= mode_d;
		end
	end

	// half period counter
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			cnt_q <= rcfd_pkg::CNT_RESET;
		end
		else
		begin
			cnt_q <= cnt_d;
		end
	end

	// divided output level
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			level_q <= 1'b0;
		end
		else
		begin
			level_q <= level_d;
		end
	end

endmodule

/* File: test/rcfd_chk.sv */
// Purpose: port checks for rcfd_divider
// Assumes: one clock domain
// Notes: bind at foot
`timescale 1ns/100ps
module rcfd_chk
(
	// clock, reset
	input wire logic clk,
	input wire logic rst,
	// register port
	input wire logic [1:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	// outputs
	input wire logic divided_clock_output,
	input wire logic divider_switch_request
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_wr_rd(a);
		reg_wr && reg_addr == a ##1 reg_rd && reg_addr == a;
	endsequence
	a_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000) else $error("rdata not idle");
	a_div_msb: assert property ($past(reg_rd) && $past(reg_addr) == 2'h1 |-> !reg_rdata[15])
		else $error("bit 15 set");
	a_trim_low: assert property ($past(reg_rd) && $past(reg_addr) == 2'h2 |-> reg_rdata[6:0] == 7'h00)
		else $error("trim low bits set");
	a_unmapped_rd: assert property ($past(reg_rd) && $past(reg_addr) == 2'h3 |-> reg_rdata == 16'h0000)
		else $error("unmapped not zero");
	a_div_hold: assert property (s_wr_rd(2'h1) |=> reg_rdata[14:0] == $past(reg_wdata[14:0], 2))
		else $error("divisor lost");
	a_trim_hold: assert property (s_wr_rd(2'h2) |=> reg_rdata[15:7] == $past(reg_wdata[15:7], 2))
		else $error("trim lost");
	a_req_set: assert property (reg_wr && reg_addr == 2'h0 && reg_wdata[0] |=> divider_switch_request)
		else $error("request not set");
	a_req_cause: assert property ($rose(divider_switch_request) |-> $past(reg_wr && reg_addr == 2'h0))
		else $error("request without write");
endmodule
bind rcfd_divider rcfd_chk u_rcfd_chk (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .divided_clock_output(divided_clock_output),
	.divider_switch_request(divider_switch_request));

/* File: test/rcfd_clk_meter.sv */
// Purpose: clock consumer flagging divided clock rises
// Assumes: output sampled on base clock
// Notes: rise_q is one cycle
`timescale 1ns/100ps
module rcfd_clk_meter
(
	// clock, reset
	input wire logic clk,
	input wire logic rst,
	// watched clock, rise flag
	input wire logic divided_clock_output,
	output logic rise_q
);
	logic prev_q;
	always_ff @(posedge clk)
	begin
		prev_q <= rst | divided_clock_output;
		rise_q <= !rst && divided_clock_output && !prev_q;
	end
endmodule

/* File: test/ref_clock_fractional_divider_tb.sv */
// Purpose: register and output tests
// Assumes: 50 MHz clock
// Notes: periods counted in base cycles
`timescale 1ns/100ps
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin n_mismatch++; \
	$display("[FAIL] %s exp %0h got %0h", n, e, s); end end
module ref_clock_fractional_divider_tb;
	logic clk, rst, reg_wr, reg_rd, divided_clock_output, divider_switch_request, rise_q;
	logic [1:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, d;
	int n_mismatch, check_count, cyc, t0;
	int t[5][4] = '{'{1, 0, 8, 16}, '{2, 0, 8, 32}, '{3, 0, 4, 24}, '{2, 256, 4, 20}, '{1, 511, 256, 1023}};
	rcfd_divider u_rcfd_divider (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .divided_clock_output(divided_clock_output),
		.divider_switch_request(divider_switch_request));
	rcfd_clk_meter u_rcfd_clk_meter (.clk(clk), .rst(rst), .divided_clock_output(divided_clock_output),
		.rise_q(rise_q));
	task final_report;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task wr(input logic [1:0] a, input logic [15:0] v);
		reg_wr <= 1'b1;
		reg_rd <= 1'b0;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk);
		#1;
	endtask
	task rd(input logic [1:0] a);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		#1 d = reg_rdata;
	endtask
	task tick;
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		@(posedge clk);
		#1;
	endtask
	task rise;
		do tick(); while (rise_q !== 1'b1);
	endtask
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_mismatch++;
			final_report();
		end
	end
	initial
	begin
		rst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 2'h0;
		reg_wdata = 16'h0000;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		tick();
		rd(2'h1);
		`CHK("div reset", 16'h0000, d)
		wr(2'h1, 16'hFFFF);
		rd(2'h1);
		`CHK("div", 16'h7FFF, d)
		wr(2'h2, 16'hFFFF);
		rd(2'h2);
		`CHK("trim", 16'hFF80, d)
		wr(2'h3, 16'hFFFF);
		rd(2'h3);
		`CHK("unmapped", 16'h0000, d)
		$display("test regs done");
		wr(2'h1, 16'h0000);
		wr(2'h0, 16'h0001);
		#1 `CHK("req set", 1'b1, divider_switch_request)
		tick();
		`CHK("req clear", 1'b0, divider_switch_request)
		#4 `CHK("pass high", 1'b1, divided_clock_output)
		#10 `CHK("pass low", 1'b0, divided_clock_output)
		tick();
		rd(2'h0);
		`CHK("bypass", 1'b1, d[1])
		$display("test bypass done");
		foreach (t[i])
		begin
			wr(2'h1, 16'(t[i][0]));
			wr(2'h2, 16'(t[i][1] << 7));
			wr(2'h0, 16'h0001);
			repeat (50) if (divider_switch_request === 1'b1) tick();
			`CHK("req done", 1'b0, divider_switch_request)
			rise();
			rise();
			t0 = cyc;
			repeat (t[i][2]) rise();
			`CHK("period", t[i][3], cyc - t0)
			$display("test div %0d done", i);
		end
		rd(2'h0);
		`CHK("divide mode", 1'b0, d[1])
		final_report();
	end
endmodule
